// ===== logic/lcd_cfg_pkg.sv
`default_nettype none
package lcd_cfg_pkg;
	// register byte addresses
	localparam logic [7:0] ctrl0_addr = 8'h00;
	localparam logic [7:0] ctrl1_addr = 8'h04;
	localparam logic [7:0] supply_addr = 8'h08;
	localparam logic [7:0] regulator_addr = 8'h0C;
	localparam logic [7:0] status_addr = 8'h10;
	localparam logic [7:0] mask_addr = 8'h14;
	// control one fields
	localparam int frame_irq_enable_bit = 7;
	localparam int complementary_drive_enable_bit = 2;
	localparam int wait_mode_disable_bit = 1;
	localparam int stop_mode_disable_bit = 0;
	// supply config fields
	localparam int bias_source_select_bit = 7;
	localparam int high_reference_select_bit = 6;
	localparam int load_adjust_lsb = 4;
	localparam int buffer_bypass_bit = 2;
	localparam int supply_source_lsb = 0;
	// control zero and regulator fields
	localparam int module_enable_bit = 7;
	localparam int regulator_enable_bit = 7;
	// writable bit masks
	localparam logic [7:0] ctrl0_mask = 8'h80;
	localparam logic [7:0] ctrl1_mask = 8'h87;
	localparam logic [7:0] supply_mask = 8'hF7;
	localparam logic [7:0] regulator_mask = 8'h80;
	// reset values
	localparam logic [7:0] ctrl0_reset = 8'h00;
	localparam logic [7:0] ctrl1_reset = 8'h00;
	localparam logic [7:0] supply_reset = 8'h00;
	localparam logic [7:0] regulator_reset = 8'h00;
	// status and mask: frame start
	localparam int frame_status_bit = 0;
	localparam logic [7:0] status_reset = 8'h00;
	localparam logic [7:0] irq_mask_reset = 8'h00;
	localparam logic [7:0] irq_mask_writable = 8'h01;
	// supply arrangements
	typedef enum logic [1:0] {
		supply_ll2_from_vdd = 2'h0,
		supply_ll3_from_vdd = 2'h1,
		supply_ll1_from_vlcd = 2'h2,
		supply_ll3_external = 2'h3
	} supply_src_t;
	// charge pump clock rates
	typedef enum logic [1:0] {
		pump_fastest = 2'h0,
		pump_mid_fast = 2'h1,
		pump_mid_slow = 2'h2,
		pump_slowest = 2'h3
	} pump_rate_t;
endpackage
`default_nettype wire

// ===== logic/lcd_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lcd_cfg_if;
	logic [7:0] ctrl0;
	logic [7:0] ctrl1;
	logic [7:0] supply;
	logic [7:0] regulator;
	modport regs (output ctrl0, output ctrl1, output supply, output regulator);
	modport ctl (input ctrl0, input ctrl1, input supply, input regulator);
endinterface
`default_nettype wire

// ===== logic/lcd_cfg_regs.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_cfg_regs
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	// register values
	lcd_cfg_if.regs cfg
);
	// all fields writable at any time, no hardware guard
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg.ctrl0 <= lcd_cfg_pkg::ctrl0_reset;
			cfg.ctrl1 <= lcd_cfg_pkg::ctrl1_reset;
			cfg.supply <= lcd_cfg_pkg::supply_reset;
			cfg.regulator <= lcd_cfg_pkg::regulator_reset;
		end
		else if (wr_en)
		begin
			case (wr_addr)
				lcd_cfg_pkg::ctrl0_addr: cfg.ctrl0 <= wr_data & lcd_cfg_pkg::ctrl0_mask;
				lcd_cfg_pkg::ctrl1_addr: cfg.ctrl1 <= wr_data & lcd_cfg_pkg::ctrl1_mask;
				lcd_cfg_pkg::supply_addr: cfg.supply <= wr_data & lcd_cfg_pkg::supply_mask;
				lcd_cfg_pkg::regulator_addr:
					cfg.regulator <= wr_data & lcd_cfg_pkg::regulator_mask;
				default: ;
			endcase
		end
	end
endmodule // lcd_cfg_regs
`default_nettype wire

// ===== logic/lcd_control_supply_config.sv
// Contract
// - frame start raises irq when enabled
// - complementary pins need enable, code 11, no regulator
// - otherwise pins open drain on main supply
// - wait-disable stops driver and pump in wait
// - stop-disable stops driver and pump in stop
// - bias select: one pump, zero resistors
// - pump clock rate from load adjust
// - resistor load from load adjust upper bit
// - buffer bypass removes op-amp buffer
// - high reference selects undivided input
// - supply field picks one of four arrangements
// - supply register read/write any time
// - module enable starts waveforms, else stopped
// - regulator only meaningful with pump on
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module lcd_control_supply_config
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power mode and frame inputs from outside
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic frame_start,
	// waveform and pump control
	output logic waveform_run,
	output logic pump_run,
	output logic resistor_run,
	output logic [1:0] pump_rate,
	output logic resistor_high_load,
	output logic buffer_bypass,
	output logic input_undivided,
	output logic regulator_run,
	output logic [1:0] supply_source_select,
	// shared pins
	output logic pins_complementary,
	output logic pins_ref_ll3,
	// interrupt
	output logic irq
);
	lcd_cfg_if cfg ();

	logic wait_s1_q, wait_s2_q;
	logic stop_s1_q, stop_s2_q;
	logic frame_s1_q, frame_s2_q, frame_s3_q;
	logic frame_pulse;
	logic access;
	logic known_addr;
	logic [7:0] status_q;
	logic [7:0] mask_q;
	logic [31:0] rdata_d;

	lcd_cfg_regs u_regs
	(
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(access && pwrite),
		.wr_addr(paddr),
		.wr_data(pwdata[7:0]),
		.cfg(cfg)
	);

	// synchronise outside levels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_s1_q <= 1'b0;
			wait_s2_q <= 1'b0;
		end
		else
		begin
			wait_s1_q <= wait_mode;
			wait_s2_q <= wait_s1_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stop_s1_q <= 1'b0;
			stop_s2_q <= 1'b0;
		end
		else
		begin
			stop_s1_q <= stop_mode;
			stop_s2_q <= stop_s1_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frame_s1_q <= 1'b0;
			frame_s2_q <= 1'b0;
			frame_s3_q <= 1'b0;
		end
		else
		begin
			frame_s1_q <= frame_start;
			frame_s2_q <= frame_s1_q;
			frame_s3_q <= frame_s2_q;
		end
	end

	assign frame_pulse = frame_s2_q && !frame_s3_q;

	// apb decode, zero wait states
	assign access = psel && penable;
	always_comb
	begin
		case (paddr)
			lcd_cfg_pkg::ctrl0_addr,
			lcd_cfg_pkg::ctrl1_addr,
			lcd_cfg_pkg::supply_addr,
			lcd_cfg_pkg::regulator_addr,
			lcd_cfg_pkg::status_addr,
			lcd_cfg_pkg::mask_addr: known_addr = 1'b1;
			default: known_addr = 1'b0;
		endcase
	end

	// status sticky, write one clears, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= lcd_cfg_pkg::status_reset;
		else
		begin
			if (access && pwrite && paddr == lcd_cfg_pkg::status_addr)
				status_q[lcd_cfg_pkg::frame_status_bit] <=
					status_q[lcd_cfg_pkg::frame_status_bit] &
					~pwdata[lcd_cfg_pkg::frame_status_bit];
			if (frame_pulse)
				status_q[lcd_cfg_pkg::frame_status_bit] <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_q <= lcd_cfg_pkg::irq_mask_reset;
		else if (access && pwrite && paddr == lcd_cfg_pkg::mask_addr)
			mask_q <= pwdata[7:0] & lcd_cfg_pkg::irq_mask_writable;
	end

	// interrupt: frame enable gates too
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= status_q[lcd_cfg_pkg::frame_status_bit]
				&& mask_q[lcd_cfg_pkg::frame_status_bit]
				&& cfg.ctrl1[lcd_cfg_pkg::frame_irq_enable_bit];
	end

	// read mux
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (paddr)
			lcd_cfg_pkg::ctrl0_addr: rdata_d[7:0] = cfg.ctrl0;
			lcd_cfg_pkg::ctrl1_addr: rdata_d[7:0] = cfg.ctrl1;
			lcd_cfg_pkg::supply_addr: rdata_d[7:0] = cfg.supply;
			lcd_cfg_pkg::regulator_addr: rdata_d[7:0] = cfg.regulator;
			lcd_cfg_pkg::status_addr: rdata_d[7:0] = status_q;
			lcd_cfg_pkg::mask_addr: rdata_d[7:0] = mask_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel && !penable && !known_addr;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else
			prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
	end

	// drive and bias control
	logic enabled, halted, pump_sel;
	assign enabled = cfg.ctrl0[lcd_cfg_pkg::module_enable_bit];
	assign halted = (wait_s2_q && cfg.ctrl1[lcd_cfg_pkg::wait_mode_disable_bit])
		|| (stop_s2_q && cfg.ctrl1[lcd_cfg_pkg::stop_mode_disable_bit]);
	assign pump_sel = cfg.supply[lcd_cfg_pkg::bias_source_select_bit];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			waveform_run <= 1'b0;
		else
			waveform_run <= enabled && !halted;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pump_run <= 1'b0;
		else
			pump_run <= enabled && !halted && pump_sel;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			resistor_run <= 1'b0;
		else
			resistor_run <= enabled && !halted && !pump_sel;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pump_rate <= 2'h0;
		else
			pump_rate <= cfg.supply[lcd_cfg_pkg::load_adjust_lsb +: 2];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			resistor_high_load <= 1'b0;
		else
			resistor_high_load <= cfg.supply[lcd_cfg_pkg::load_adjust_lsb + 1];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			buffer_bypass <= 1'b0;
		else
			buffer_bypass <= cfg.supply[lcd_cfg_pkg::buffer_bypass_bit];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			input_undivided <= 1'b0;
		else
			input_undivided <= cfg.supply[lcd_cfg_pkg::high_reference_select_bit];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			regulator_run <= 1'b0;
		else
			regulator_run <= cfg.regulator[lcd_cfg_pkg::regulator_enable_bit]
				&& enabled && !halted && pump_sel;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			supply_source_select <= 2'h0;
		else
			supply_source_select <= cfg.supply[lcd_cfg_pkg::supply_source_lsb +: 2];
	end

	// shared pin drive mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pins_complementary <= 1'b0;
			pins_ref_ll3 <= 1'b0;
		end
		else
		begin
			pins_complementary <= cfg.ctrl1[lcd_cfg_pkg::complementary_drive_enable_bit]
				&& cfg.supply[lcd_cfg_pkg::supply_source_lsb +: 2]
					== lcd_cfg_pkg::supply_ll3_external
				&& !cfg.regulator[lcd_cfg_pkg::regulator_enable_bit];
			pins_ref_ll3 <= cfg.ctrl1[lcd_cfg_pkg::complementary_drive_enable_bit]
				&& cfg.supply[lcd_cfg_pkg::supply_source_lsb +: 2]
					== lcd_cfg_pkg::supply_ll3_external
				&& !cfg.regulator[lcd_cfg_pkg::regulator_enable_bit];
		end
	end
endmodule // lcd_control_supply_config
`default_nettype wire

// ===== bench/lcd_panel_model.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_panel_model #(parameter int frame_len = 16)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// drive seen by the glass
	input wire logic waveform_run,
	// frame timing back to the block
	output logic frame_start
);
	logic [7:0] cnt_q;
	// frames advance only while waveforms run
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cnt_q <= 8'h00;
		else if (waveform_run)
			cnt_q <= (cnt_q == 8'(frame_len - 1)) ? 8'h00 : cnt_q + 8'h01;
	assign frame_start = waveform_run && (cnt_q < 8'(frame_len / 2));
endmodule // lcd_panel_model
`default_nettype wire

// ===== bench/lcd_cfg_props.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_cfg_props
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// drive outputs
	input wire logic waveform_run,
	input wire logic pump_run,
	input wire logic resistor_run,
	input wire logic [1:0] pump_rate,
	input wire logic resistor_high_load,
	input wire logic regulator_run,
	input wire logic [1:0] supply_source_select,
	input wire logic pins_complementary,
	input wire logic pins_ref_ll3,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_zero_wait: assert property (pready == (psel && penable))
		else $error("pready not in access phase");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_error_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	a_bias_exclusive: assert property (!(pump_run && resistor_run))
		else $error("pump and resistors both on");
	a_pump_needs_run: assert property (pump_run |-> waveform_run || $past(waveform_run))
		else $error("pump without module running");
	a_reg_needs_pump: assert property (regulator_run |-> pump_run || $past(pump_run))
		else $error("regulator without pump");
	a_load_upper_bit: assert property (resistor_high_load == pump_rate[1])
		else $error("load setting differs from rate code");
	a_pins_need_code: assert property (pins_complementary |-> supply_source_select == 2'h3)
		else $error("complementary pins on wrong supply");
	a_pins_ref_pair: assert property (pins_ref_ll3 == pins_complementary)
		else $error("pin reference differs from drive mode");
	c_irq: cover property (irq);
	c_pins: cover property (pins_complementary);
	c_err: cover property (pslverr);
	c_pump: cover property (pump_run);
endmodule // lcd_cfg_props
bind lcd_control_supply_config lcd_cfg_props u_props (.pclk, .presetn, .psel, .penable,
	.prdata, .pready, .pslverr, .waveform_run, .pump_run, .resistor_run, .pump_rate,
	.resistor_high_load, .regulator_run, .supply_source_select, .pins_complementary,
	.pins_ref_ll3, .irq);
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic pclk, presetn, psel, penable, pwrite, wait_mode, stop_mode, frame_start, pready, pslverr;
	logic waveform_run, pump_run, resistor_run, resistor_high_load, buffer_bypass;
	logic input_undivided, regulator_run, pins_complementary, pins_ref_ll3, irq, rerr;
	logic [1:0] pump_rate, supply_source_select;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [7:0] wm [4] = '{8'h80, 8'h87, 8'hF7, 8'h80};
	int errors = 0;
	int cmp_count = 0;
	lcd_control_supply_config u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .wait_mode, .stop_mode, .frame_start,
		.waveform_run, .pump_run, .resistor_run, .pump_rate, .resistor_high_load,
		.buffer_bypass, .input_undivided, .regulator_run, .supply_source_select,
		.pins_complementary, .pins_ref_ll3, .irq);
	lcd_panel_model #(.frame_len(16)) u_panel (.pclk, .presetn, .waveform_run, .frame_start);
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			errors++;
		rdata = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, e, rdata);
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, wait_mode, stop_mode, presetn} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd("reset", 8'(4 * i), 32'h0);
		for (int i = 3; i >= 0; i--)
		begin
			xfer(1'b1, 8'(4 * i), 32'hFF);
			rd("access", 8'(4 * i), {24'h0, wm[i]});
		end
		xfer(1'b0, 8'h18, 32'h0);
		chk("unmapped", {rerr, rdata[30:0]}, 32'h80000000);
		xfer(1'b1, lcd_cfg_pkg::ctrl0_addr, 32'h0);
		xfer(1'b1, lcd_cfg_pkg::regulator_addr, 32'h0);
		xfer(1'b1, lcd_cfg_pkg::ctrl1_addr, 32'h04);
		for (int c = 0; c < 4; c++)
		begin
			xfer(1'b1, lcd_cfg_pkg::supply_addr, 32'(c));
			tick(2);
			chk("supply", {28'h0, pins_ref_ll3, pins_complementary, supply_source_select},
				32'(12 * (c / 3) + c));
		end
		xfer(1'b1, lcd_cfg_pkg::regulator_addr, 32'h80);
		tick(2);
		chk("pins", 32'(pins_complementary), 32'h0);
		xfer(1'b1, lcd_cfg_pkg::ctrl1_addr, 32'h0);
		xfer(1'b1, lcd_cfg_pkg::ctrl0_addr, 32'h80);
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, lcd_cfg_pkg::supply_addr, 32'({i[0], i[1], i[1:0], 1'b0, !i[0], 2'b11}));
			tick(2);
			chk("bias", {24'h0, pump_run, resistor_run, pump_rate, resistor_high_load,
				buffer_bypass, input_undivided, regulator_run},
				32'({i[0], !i[0], i[1:0], i[1], !i[0], i[1], i[0]}));
		end
		for (int m = 0; m < 2; m++)
		begin
			@(posedge pclk);
			{wait_mode, stop_mode} <= (m == 0) ? 2'b10 : 2'b01;
			xfer(1'b1, lcd_cfg_pkg::ctrl1_addr, m ? 32'h2 : 32'h1);
			tick(5);
			chk("running", 32'(waveform_run), 32'h1);
			xfer(1'b1, lcd_cfg_pkg::ctrl1_addr, m ? 32'h1 : 32'h2);
			tick(5);
			chk("halted", {30'h0, waveform_run, pump_run}, 32'h0);
		end
		@(posedge pclk);
		{wait_mode, stop_mode} <= 2'b00;
		xfer(1'b1, lcd_cfg_pkg::mask_addr, 32'h1);
		xfer(1'b1, lcd_cfg_pkg::ctrl1_addr, 32'h80);
		tick(40);
		chk("irq on", 32'(irq), 32'h1);
		xfer(1'b1, lcd_cfg_pkg::ctrl1_addr, 32'h0);
		tick(2);
		chk("irq off", 32'(irq), 32'h0);
		xfer(1'b1, lcd_cfg_pkg::mask_addr, 32'h0);
		xfer(1'b1, lcd_cfg_pkg::ctrl1_addr, 32'h80);
		tick(2);
		chk("irq masked", 32'(irq), 32'h0);
		xfer(1'b1, lcd_cfg_pkg::ctrl0_addr, 32'h0);
		rd("status", lcd_cfg_pkg::status_addr, 32'h1);
		xfer(1'b1, lcd_cfg_pkg::status_addr, 32'h1);
		rd("cleared", lcd_cfg_pkg::status_addr, 32'h0);
		tick(40);
		chk("stopped", 32'(waveform_run), 32'h0);
		rd("no frames", lcd_cfg_pkg::status_addr, 32'h0);
		xfer(1'b1, lcd_cfg_pkg::ctrl0_addr, 32'h80);
		tick(40);
		xfer(1'b1, lcd_cfg_pkg::mask_addr, 32'h1);
		tick(2);
		chk("irq frame", 32'(irq), 32'h1);
		rd("frame set", lcd_cfg_pkg::status_addr, 32'h1);
		wrap_up;
	end
	initial
	begin
		#100000;
		errors++;
		wrap_up;
	end
endmodule // tb
`default_nettype wire
